//--- shared/svm_pkg.sv
// Overview of operation
// - Monitor 0 sees drops only; reset holds while below, then a delay.
// - Monitors 1 and 2 detect crossings in both directions.
// - Monitor 1 restarts a delay after recovery or from the drop.
// - Monitor 2 offers the same restart choice as monitor 1.
// - Monitor 0 level comes from a two-bit option field, three levels.
// - Monitors 1 and 2 take four-bit level fields, three codes allowed.
// - Monitors 1 and 2 show a live flag for above or below threshold.
// - Monitors 1 and 2 set a sticky flag on every detected crossing.
// - Monitors 1, 2 interrupt as NMI or maskable; monitor 0 never does.
// - The interrupt fires on a fall, a rise or either, as selected.
// - Monitor 0 has no filter; monitors 1 and 2 have a switchable one.
// - Filter ticks are the slow oscillator divided by 2, 4, 8 or 16.
// - Monitors 1 and 2 pulse an event-link output on each crossing.
// - The reset cause register marks monitors 0, 1, 2 in bits 1, 2, 3.
package svm_pkg;
	localparam int unsigned CLK_PERIOD_NS   = 50;
	localparam int unsigned RESTART_TIME_NS = 100000;
	localparam int unsigned RESTART_CYCLES  =
		(RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 16;

	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] OFF_LEVEL_SEL = 5'h00;
	localparam logic [4:0] OFF_CTL1      = 5'h04;
	localparam logic [4:0] OFF_STS1      = 5'h08;
	localparam logic [4:0] OFF_CTL2      = 5'h0C;
	localparam logic [4:0] OFF_STS2      = 5'h10;
	localparam logic [4:0] OFF_CAUSE     = 5'h14;

	localparam int unsigned CTL_W    = 10;
	localparam int unsigned CTL_EN   = 0;
	localparam int unsigned CTL_RST  = 1;
	localparam int unsigned CTL_MODE = 2;
	localparam int unsigned CTL_MASK = 3;
	localparam int unsigned CTL_EDGE = 4;
	localparam int unsigned CTL_FILT = 6;
	localparam int unsigned CTL_DIV  = 8;
	localparam logic [9:0]  CTL_RESET = 10'h000;

	localparam int unsigned STS_DET = 0;
	localparam int unsigned STS_MON = 1;

	localparam int unsigned CAUSE_W    = 8;
	localparam int unsigned CAUSE_MON0 = 1;

	localparam int unsigned OPT_W    = 2;
	localparam int unsigned LVL_W    = 4;
	localparam int unsigned LVL1_POS = 0;
	localparam int unsigned LVL2_POS = 4;
	localparam logic [3:0]  LVL_MAX  = 4'h2;
	localparam logic [7:0]  LVL_SEL_RESET = 8'h00;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BOTH = 2'b10
	} svm_edge_type;

	function automatic logic [3:0] svm_div_last(input logic [1:0] sel);
		svm_div_last = 4'(({1'b0, 4'h2} << sel) - 5'h01);
	endfunction : svm_div_last

	function automatic logic svm_edge_hit(input logic [1:0] sel,
		input logic rise, input logic fall);
		unique case (sel)
			EDGE_FALL: svm_edge_hit = fall;
			EDGE_RISE: svm_edge_hit = rise;
			EDGE_BOTH: svm_edge_hit = rise | fall;
			default:   svm_edge_hit = 1'b0;
		endcase
	endfunction : svm_edge_hit
endpackage : svm_pkg

//--- hdl/svm_monitor.sv
module svm_monitor import svm_pkg::*; #(
	parameter int unsigned RESTART_CYCLES_P = RESTART_CYCLES
) (
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	input  wire logic [ADDR_W-1:0] avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic [31:0]            avs_readdata_out,
	output logic                   avs_waitrequest_out,
	input  wire logic [2:0]        comparator_above_in,
	input  wire logic              slow_internal_oscillator_in,
	input  wire logic [OPT_W-1:0]  option_setting_word_1_in,
	output logic [OPT_W-1:0]       monitor0_level_select_out,
	output logic [LVL_W-1:0]       monitor1_level_field_out,
	output logic [LVL_W-1:0]       monitor2_level_field_out,
	output logic                   cpu_reset_out,
	output logic                   nmi_out,
	output logic                   irq_out,
	output logic [1:0]             event_link_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [2:0] cmp_m_q;
	logic [2:0] cmp_s_q;
	logic       osc_m_q;
	logic       osc_s_q;
	logic       osc_d_q;
	logic       osc_edge;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cmp_m_q <= 3'h7;
			cmp_s_q <= 3'h7;
			osc_m_q <= 1'b0;
			osc_s_q <= 1'b0;
			osc_d_q <= 1'b0;
		end else begin
			cmp_m_q <= comparator_above_in;
			cmp_s_q <= cmp_m_q;
			osc_m_q <= slow_internal_oscillator_in;
			osc_s_q <= osc_m_q;
			osc_d_q <= osc_s_q;
		end
	end

	assign osc_edge = osc_s_q & ~osc_d_q;

	// ------------------------------------------------------------
	// Bus slave: one wait state, writes land on the release edge
	// ------------------------------------------------------------
	logic        ack_q;
	logic        req;
	logic        wr_stb;
	logic [31:0] rd_d;
	logic [31:0] rd_q;

	assign req                 = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & ~ack_q;
	assign wr_stb              = avs_write_in & ack_q;
	assign avs_readdata_out    = rd_q;
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			be_merge[b*8 +: 8] = be[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
		end
	endfunction : be_merge
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_q <= 1'b0;
			rd_q  <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			if (avs_read_in && !ack_q) begin
				rd_q <= rd_d;
			end
		end
	end

	// ------------------------------------------------------------
	// Level selects
	// ------------------------------------------------------------
	logic [7:0]       lvl_sel_q;
	logic [7:0]       lvl_new;
	logic [OPT_W-1:0] lvl0_q;
	logic             opt_done_q;
	assign lvl_new = 8'(be_merge({24'h0, lvl_sel_q}, avs_writedata_in,
		avs_byteenable_in));
	// Codes above the permitted three are dropped, the field keeps its value
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lvl_sel_q <= LVL_SEL_RESET;
		end else if (wr_stb && avs_address_in == OFF_LEVEL_SEL) begin
			if (lvl_new[LVL1_POS +: LVL_W] <= LVL_MAX) begin
				lvl_sel_q[LVL1_POS +: LVL_W] <= lvl_new[LVL1_POS +: LVL_W];
			end
			if (lvl_new[LVL2_POS +: LVL_W] <= LVL_MAX) begin
				lvl_sel_q[LVL2_POS +: LVL_W] <= lvl_new[LVL2_POS +: LVL_W];
			end
		end
	end
	// Option word is static memory; caught once after reset release
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lvl0_q     <= '0;
			opt_done_q <= 1'b0;
		end else if (!opt_done_q) begin
			lvl0_q     <= option_setting_word_1_in;
			opt_done_q <= 1'b1;
		end
	end

	assign monitor0_level_select_out = lvl0_q;
	assign monitor1_level_field_out  = lvl_sel_q[LVL1_POS +: LVL_W];
	assign monitor2_level_field_out  = lvl_sel_q[LVL2_POS +: LVL_W];

	// ------------------------------------------------------------
	// Monitors 1 and 2: control, filter, crossings, status
	// ------------------------------------------------------------
	logic [CTL_W-1:0] ctl_q  [1:2];
	logic             filt_q [1:2];
	logic             det_q  [1:2];
	logic [2:0]       below_w;
	logic [2:0]       fall_w;
	logic [2:0]       ren_w;
	logic [2:0]       mode_w;
	logic [2:1]       int_req;
	logic [2:1]       int_mask;
	logic [2:1]       cross_w;
	logic [2:0]       rst_q;

	assign below_w[0] = ~cmp_s_q[0];
	assign fall_w[0]  = 1'b0;
	assign ren_w[0]   = 1'b1;
	assign mode_w[0]  = 1'b0;
	for (genvar g = 1; g <= 2; g++) begin : g_mon
		localparam logic [4:0] OFF_C = (g == 1) ? OFF_CTL1 : OFF_CTL2;
		localparam logic [4:0] OFF_S = (g == 1) ? OFF_STS1 : OFF_STS2;
		logic [3:0] div_q;
		logic       samp_q;
		logic       prev_q;
		logic       tick;
		logic       rise;
		logic       fall;
		logic       en;
		logic       clr;
		assign en   = ctl_q[g][CTL_EN];
		assign tick = osc_edge &&
			div_q == svm_div_last(ctl_q[g][CTL_DIV +: 2]);
		assign rise = en & filt_q[g] & ~prev_q;
		assign fall = en & ~filt_q[g] & prev_q;
		assign clr  = wr_stb && avs_address_in == OFF_S &&
			avs_byteenable_in[0] && !avs_writedata_in[STS_DET];

		always_ff @(posedge clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				ctl_q[g] <= CTL_RESET;
			end else if (wr_stb && avs_address_in == OFF_C) begin
				ctl_q[g] <= CTL_W'(be_merge(32'(ctl_q[g]),
					avs_writedata_in, avs_byteenable_in));
			end
		end

		// Two matching samples pass a new level; off means direct
		always_ff @(posedge clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				div_q    <= 4'h0;
				samp_q   <= 1'b1;
				filt_q[g] <= 1'b1;
			end else if (!ctl_q[g][CTL_FILT]) begin
				div_q     <= 4'h0;
				samp_q    <= cmp_s_q[g];
				filt_q[g] <= cmp_s_q[g];
			end else begin
				if (osc_edge) begin
					div_q <= tick ? 4'h0 : 4'(div_q + 4'h1);
				end
				if (tick) begin
					samp_q <= cmp_s_q[g];
					if (samp_q == cmp_s_q[g]) begin
						filt_q[g] <= cmp_s_q[g];
					end
				end
			end
		end

		// Sticky flag: a crossing in the clearing cycle still sets it
		always_ff @(posedge clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				prev_q   <= 1'b1;
				det_q[g] <= 1'b0;
			end else begin
				prev_q <= filt_q[g];
				if (rise || fall) begin
					det_q[g] <= 1'b1;
				end else if (clr) begin
					det_q[g] <= 1'b0;
				end
			end
		end

		assign cross_w[g]  = rise | fall;
		assign below_w[g]  = ~filt_q[g];
		assign fall_w[g]   = fall;
		assign ren_w[g]    = en & ctl_q[g][CTL_RST];
		assign mode_w[g]   = ctl_q[g][CTL_MODE];
		assign int_mask[g] = ctl_q[g][CTL_MASK];
		assign int_req[g]  = en & ~ctl_q[g][CTL_RST] &
			svm_edge_hit(ctl_q[g][CTL_EDGE +: 2], rise, fall);

		crossing_flag_a: assert property (cross_w[g] |=> det_q[g])
			else $error("crossing did not set sticky flag");
		event_pulse_a: assert property (cross_w[g] |=> event_link_out[g-1])
			else $error("crossing gave no event pulse");
		edge_gate_a: assert property (
			(ctl_q[g][CTL_EDGE +: 2] == EDGE_FALL && !fall) |-> !int_req[g])
			else $error("interrupt on unselected direction");
		crossing_restart_a: assert property (
			(ren_w[g] && mode_w[g] && fall) |-> ##2 rst_q[g] [*4])
			else $error("crossing restart did not hold reset");
	end

	// ------------------------------------------------------------
	// Reset timers: level mode or crossing mode
	// ------------------------------------------------------------
	logic [CNT_W-1:0] cnt_q [0:2];
	logic [CAUSE_W-1:0] cause_q;

	for (genvar m = 0; m <= 2; m++) begin : g_rst
		always_ff @(posedge clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				cnt_q[m] <= '0;
				rst_q[m] <= 1'b0;
			end else begin
				if (!ren_w[m]) begin
					cnt_q[m] <= '0;
				end else if ((!mode_w[m] && below_w[m]) ||
					(mode_w[m] && fall_w[m])) begin
					cnt_q[m] <= CNT_W'(RESTART_CYCLES_P);
				end else if (cnt_q[m] != '0) begin
					cnt_q[m] <= CNT_W'(cnt_q[m] - 1'b1);
				end
				rst_q[m] <= ren_w[m] & ((!mode_w[m] && below_w[m]) ||
					(cnt_q[m] != '0));
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cause_q <= '0;
		end else begin
			for (int m = 0; m <= 2; m++) begin
				if (rst_q[m]) begin
					cause_q[CAUSE_MON0 + m] <= 1'b1;
				end
			end
		end
	end

	assign cpu_reset_out = |rst_q;

	// ------------------------------------------------------------
	// Interrupt and event outputs
	// ------------------------------------------------------------
	logic       nmi_q;
	logic       irq_q;
	logic [1:0] evt_q;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			nmi_q <= 1'b0;
			irq_q <= 1'b0;
			evt_q <= 2'b00;
		end else begin
			nmi_q <= |(int_req & ~int_mask);
			irq_q <= |(int_req & int_mask);
			evt_q <= cross_w;
		end
	end

	assign nmi_out        = nmi_q;
	assign irq_out        = irq_q;
	assign event_link_out = evt_q;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (avs_address_in)
			OFF_LEVEL_SEL: rd_d[7:0] = lvl_sel_q;
			OFF_CTL1:      rd_d[CTL_W-1:0] = ctl_q[1];
			OFF_CTL2:      rd_d[CTL_W-1:0] = ctl_q[2];
			OFF_STS1:      rd_d[STS_DET +: 2] = {filt_q[1], det_q[1]};
			OFF_STS2:      rd_d[STS_DET +: 2] = {filt_q[2], det_q[2]};
			OFF_CAUSE:     rd_d[CAUSE_W-1:0] = cause_q;
			default:       rd_d = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_mon0_recover;
		!cmp_s_q[0] ##1 cmp_s_q[0];
	endsequence

	mon0_reset_a: assert property (!cmp_s_q[0] |=> cpu_reset_out)
		else $error("monitor 0 low without reset");
	mon0_release_a: assert property (s_mon0_recover |-> rst_q[0] [*8])
		else $error("monitor 0 released without delay");
	cause_record_a: assert property ($rose(rst_q[1]) |=> cause_q[2])
		else $error("monitor 1 reset cause not recorded");
	mon0_no_int_a: assert property (
		(!cmp_s_q[0] && int_req == 2'b00) |=> !nmi_out && !irq_out)
		else $error("monitor 0 raised an interrupt");
	level_guard_a: assert property (
		(wr_stb && avs_address_in == OFF_LEVEL_SEL && avs_byteenable_in[0] &&
		avs_writedata_in[3:0] > LVL_MAX) |=> $stable(monitor1_level_field_out))
		else $error("illegal level code accepted");
	opt_hold_a: assert property (opt_done_q |=> $stable(lvl0_q))
		else $error("monitor 0 level changed after capture");
	live_level_a: assert property (
		(!ctl_q[1][CTL_FILT] && $stable(cmp_s_q[1])) [*3] |->
		filt_q[1] == cmp_s_q[1])
		else $error("level flag does not follow comparator");
	nmi_route_a: assert property (
		(int_req[1] && !int_mask[1]) |=> nmi_out)
		else $error("non-maskable request lost");

endmodule : svm_monitor

//--- bench/svm_supply_model.sv
module svm_supply_model (
	input  wire logic [7:0] supply_in,
	input  wire logic [1:0] sel0_in,
	input  wire logic [3:0] sel1_in,
	input  wire logic [3:0] sel2_in,
	output logic      [2:0] above_out,
	output logic            osc_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Comparators
	// ----------------------------------------
	// No hysteresis, so the bench keeps supply values clear of every level
	always_comb begin
		above_out[0] = supply_in > 8'h20 + {4'h0, sel0_in, 2'h0};
		above_out[1] = supply_in > 8'h40 + {2'h0, sel1_in, 2'h0};
		above_out[2] = supply_in > 8'h60 + {2'h0, sel2_in, 2'h0};
	end
	// ----------------------------------------
	// Slow oscillator
	// ----------------------------------------
	// Free running, phase unrelated to the system clock
	initial begin
		osc_out = 1'b0;
		#37;
		forever #100 osc_out = ~osc_out;
	end
endmodule : svm_supply_model

//--- bench/test_supply_voltage_monitor_logic.sv
module test_supply_voltage_monitor_logic;
	timeunit 1ns;
	timeprecision 1ns;
	import svm_pkg::*;
	localparam int RST = 10;
	logic        clk_in, arst_n_in, rd, wr, wt, crst, nmi, irq, osc;
	logic [4:0]  adr;
	logic [31:0] wd, rdat;
	logic [3:0]  be, sel1, sel2;
	logic [2:0]  above;
	logic [1:0]  opt, sel0, ev;
	logic [7:0]  supply;
	int          errors, total_checks, hi, c_nmi, c_irq, c_ev[2];
	int          m_ctl[2], m_lvl[2], m_det[2], m_ab[3];
	int          m_nmi, m_irq, m_ev[2], m_cause, m_opt;

	svm_monitor #(.RESTART_CYCLES_P(RST)) i_dut (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_byteenable_in(be), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wt), .comparator_above_in(above),
		.slow_internal_oscillator_in(osc),
		.option_setting_word_1_in(opt),
		.monitor0_level_select_out(sel0),
		.monitor1_level_field_out(sel1),
		.monitor2_level_field_out(sel2), .cpu_reset_out(crst),
		.nmi_out(nmi), .irq_out(irq), .event_link_out(ev));
	svm_supply_model i_supply (.supply_in(supply), .sel0_in(sel0),
		.sel1_in(sel1), .sel2_in(sel2), .above_out(above), .osc_out(osc));

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// ----------------------------------------
	// Pulse and reset counters
	// ----------------------------------------
	always @(posedge clk_in) begin
		c_nmi += int'(nmi === 1'b1);
		c_irq += int'(irq === 1'b1);
		c_ev[0] += int'(ev[0] === 1'b1);
		c_ev[1] += int'(ev[1] === 1'b1);
		hi += int'(crst === 1'b1);
	end

	// ----------------------------------------
	// Checks and bus tasks
	// ----------------------------------------
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		adr <= a;
		wd <= d;
		be <= b;
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk_in);
			if (++n > 20) begin
				chk("waitrequest", 32'h0, {31'h0, wt});
				conclude();
			end
		end while (wt !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic wrt(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hF, q);
	endtask : wrt

	task automatic rdc(input string s, input logic [4:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hF, q);
		chk(s, e, q);
	endtask : rdc

	task automatic setc(input int n, input int v);
		wrt(n ? OFF_CTL2 : OFF_CTL1, 32'(v));
		m_ctl[n] = v;
	endtask : setc

	function automatic int thr(input int n);
		return n == 0 ? 32 + 4 * m_opt : 32 + 32 * n + 4 * m_lvl[n - 1];
	endfunction : thr

	// Moves the supply, lets it settle, then compares with the model
	task automatic go(input int v, input int w);
		int ab, c, r;
		@(negedge clk_in) hi = 0;
		@(posedge clk_in) supply <= 8'(v);
		repeat (w) @(posedge clk_in);
		for (int n = 0; n < 3; n++) begin
			ab = int'(v > thr(n));
			c = n ? m_ctl[n - 1] : 0;
			if (ab != m_ab[n] && n == 0 && !ab) m_cause |= 2;
			if (ab != m_ab[n] && c[0]) begin
				m_ev[n - 1]++;
				m_det[n - 1] = 1;
				if (c[1] && !ab) m_cause |= 1 << (n + 1);
				else if (!c[1] && (c[5:4] == 2 || c[5:4] == ab)) begin
					if (c[3]) m_irq++;
					else m_nmi++;
				end
			end
			m_ab[n] = ab;
		end
		r = int'(!m_ab[0]);
		for (int n = 0; n < 2; n++) begin
			c = m_ctl[n];
			if (c[0] && c[1] && !c[2] && !m_ab[n + 1]) r = 1;
		end
		@(negedge clk_in);
		chk("nmi pulses", 32'(m_nmi), 32'(c_nmi));
		chk("irq pulses", 32'(m_irq), 32'(c_irq));
		chk("event 1", 32'(m_ev[0]), 32'(c_ev[0]));
		chk("event 2", 32'(m_ev[1]), 32'(c_ev[1]));
		chk("cpu reset", 32'(r), {31'h0, crst});
		rdc("cause", OFF_CAUSE, 32'(m_cause));
		for (int n = 0; n < 2; n++) begin
			if (m_ctl[n] & 1) rdc("status", n ? OFF_STS2 : OFF_STS1,
				32'(m_det[n] + 2 * m_ab[n + 1]));
		end
	endtask : go

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] q;
		int          n;
		void'($urandom(32'hE486F7C7));
		m_opt = $urandom % 3;
		opt = 2'(m_opt);
		supply = 8'hF0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 5'h00;
		wd = 32'h0;
		be = 4'hF;
		arst_n_in = 1'b0;
		m_ab = '{1, 1, 1};
		repeat (4) @(posedge clk_in);
		arst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk("level select 0", 32'(m_opt), {30'h0, sel0});
		rdc("cause reset", OFF_CAUSE, 32'h0);
		rdc("unmapped", 5'h18, 32'h0);
		wrt(OFF_CAUSE, 32'hE);
		rdc("cause read only", OFF_CAUSE, 32'h0);
		wrt(OFF_LEVEL_SEL, 32'h21);
		wrt(OFF_LEVEL_SEL, 32'h33);
		rdc("level register", OFF_LEVEL_SEL, 32'h21);
		chk("level fields", 32'h21, {24'h0, sel2, sel1});
		m_lvl = '{$urandom % 3, $urandom % 3};
		wrt(OFF_LEVEL_SEL, 32'(m_lvl[1] * 16 + m_lvl[0]));
		setc(0, 'h21);
		setc(1, 'h09);
		go(80 + $urandom % 8, 40);
		go(44 + $urandom % 8, 40);
		go(160 + $urandom % 64, 40);
		bus(1'b1, OFF_STS1, 32'h0, 4'h1, q);
		m_det[0] = 0;
		rdc("cleared", OFF_STS1, 32'h2);
		setc(1, 0);
		for (n = 0; n < 4; n++) begin
			setc(0, 1 + n * 16 + (n & 1) * 8);
			go(44 + $urandom % 8, 40);
			go(160 + $urandom % 64, 40);
		end
		setc(0, 7);
		go(44 + $urandom % 8, 40);
		chk("crossing restart", 1, hi >= RST && hi <= RST + 3);
		go(160 + $urandom % 64, 40);
		setc(0, 0);
		setc(1, 3);
		go(80 + $urandom % 8, 40);
		go(160 + $urandom % 64, 40);
		chk("restart delay 2", 1, hi >= RST && hi <= RST + 6);
		setc(1, 7);
		go(80 + $urandom % 8, 40);
		chk("crossing restart 2", 1, hi >= RST && hi <= RST + 3);
		go(160 + $urandom % 64, 40);
		setc(1, 0);
		go($urandom % 16, 40);
		go(160 + $urandom % 64, 40);
		chk("restart delay 0", 1, hi >= RST && hi <= RST + 6);
		for (n = 0; n < 4; n++) begin
			setc(0, 'h61 + n * 256);
			@(posedge clk_in) supply <= 8'd44;
			repeat (6 << n) @(posedge clk_in);
			chk("filtered early", 32'(m_ev[0]), 32'(c_ev[0]));
			go(44, 40 + (32 << n));
			go(200, 40 + (32 << n));
		end
		@(posedge clk_in) supply <= 8'd44;
		repeat (2) @(posedge clk_in) supply <= 8'd200;
		go(200, 300);
		conclude();
	end
endmodule : test_supply_voltage_monitor_logic
